//--- src/tlio_defines.svh
// Register offsets, reset values and line masks of the twelve-line port
`ifndef TLIO_DEFINES_SVH
`define TLIO_DEFINES_SVH
`define TLIO_FIRST_PORT_ADDR      8'h12
`define TLIO_FIRST_PORT_DIR_ADDR  8'h13
`define TLIO_SECOND_PORT_ADDR     8'h14
`define TLIO_SECOND_PORT_DIR_ADDR 8'h15
`define TLIO_DATA_RESET           8'hFF
`define TLIO_DIR_RESET            8'hFF
`define TLIO_SECOND_PORT_LINES    8'hCC
`endif

//--- src/tlio_pkg.sv
// Types shared by the twelve-line port
package tlio_pkg;
    typedef enum logic [1:0] {
        TLIO_PUSH_PULL,
        TLIO_OPEN_DRAIN_LOW,
        TLIO_OPEN_DRAIN_HIGH
    } tlio_drive_e;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } tlio_pad_s;
endpackage

//--- src/tlio_port.sv
// Twelve-line bidirectional port with data latches and direction registers
// Functional notes
// - Twelve lines, data at 12H and 14H
// - Input-line reads sample pads directly, not latched
// - Output latch holds until rewritten
// - Direction registers at 13H and 15H
// - Direction 1 input, 0 output
// - Read returns pad or latch per direction
// - Push-pull or open-drain, open-drain first port only
// - After reset all lines undriven
// - Bit operations read-modify-write whole port
// - Every first-port input line can wake device
// - Pull only when optioned, pull-down first port
`timescale 1ns/1ps
`include "tlio_defines.svh"
module tlio_port #(
    parameter logic [15:0] DRIVE_A      = 16'h0000,
    parameter logic [7:0]  WAKE_EN      = 8'hFF,
    parameter logic [7:0]  PULL_UP_A    = 8'h00,
    parameter logic [7:0]  PULL_DOWN_A  = 8'h00,
    parameter logic [7:0]  PULL_UP_B    = 8'h00,
    parameter logic [7:0]  PULL_DOWN_B  = 8'h00
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [7:0] addr,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    input  wire logic [7:0] first_port_in,
    output logic      [7:0] first_port_out,
    output logic      [7:0] first_port_oe,
    input  wire logic [7:0] second_port_in,
    output logic      [7:0] second_port_out,
    output logic      [7:0] second_port_oe,
    output logic      [7:0] first_port_pull_up,
    output logic      [7:0] first_port_pull_down,
    output logic      [7:0] second_port_pull_up,
    output logic      [7:0] second_port_pull_down,
    input  wire logic       halted,
    output logic            wake
);
    logic [7:0] first_port;
    logic [7:0] first_port_direction;
    logic [7:0] second_port;
    logic [7:0] second_port_direction;
    logic [7:0] first_meta;
    logic [7:0] first_sync;
    logic [7:0] second_meta;
    logic [7:0] second_sync;
    logic [7:0] first_prev;
    logic [7:0] next_rd_data;
    logic       next_wake;
    wire  [7:0] a_drive;

    // Drive bundle of each port: latch value and enable
    tlio_pkg::tlio_pad_s pad_a;
    tlio_pkg::tlio_pad_s pad_b;

    function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] pad,
                                             input logic [7:0] latch, input logic [7:0] lines);
        port_view = (dir & lines & pad) | (~(dir & lines) & latch);
    endfunction

    wire sel_a  = (addr == `TLIO_FIRST_PORT_ADDR);
    wire sel_ad = (addr == `TLIO_FIRST_PORT_DIR_ADDR);
    wire sel_b  = (addr == `TLIO_SECOND_PORT_ADDR);
    wire sel_bd = (addr == `TLIO_SECOND_PORT_DIR_ADDR);
    wire [7:0] second_lines = `TLIO_SECOND_PORT_LINES;
    wire [7:0] view_a = port_view(first_port_direction, first_sync, first_port, 8'hFF);
    wire [7:0] view_b = port_view(second_port_direction, second_sync, second_port, second_lines);

    // Pad samples pass two flops; reads take the current sample, not a stored copy
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            first_meta  <= 8'h00;
            first_sync  <= 8'h00;
            second_meta <= 8'h00;
            second_sync <= 8'h00;
            first_prev  <= 8'h00;
        end else begin
            first_meta  <= first_port_in;
            first_sync  <= first_meta;
            second_meta <= second_port_in;
            second_sync <= second_meta;
            first_prev  <= first_sync;
        end
    end

    // Latches change only on a write; a bit op writes back the whole merged byte
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            first_port            <= `TLIO_DATA_RESET;
            first_port_direction  <= `TLIO_DIR_RESET;
            second_port           <= `TLIO_DATA_RESET;
            second_port_direction <= `TLIO_DIR_RESET;
        end else if (wr_en) begin
            if (sel_a)
                first_port <= wr_data;
            if (sel_ad)
                first_port_direction <= wr_data;
            if (sel_b)
                second_port <= wr_data;
            if (sel_bd)
                second_port_direction <= wr_data;
        end
    end

    assign next_rd_data = !rd_en ? rd_data :
                          sel_a  ? view_a :
                          sel_ad ? first_port_direction :
                          sel_b  ? view_b :
                          sel_bd ? second_port_direction : 8'h00;

    wire [7:0] falls = first_prev & ~first_sync;
    assign next_wake = halted && ((WAKE_EN & first_port_direction & falls) != 8'h00);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 8'h00;
            wake    <= 1'b0;
        end else begin
            rd_data <= next_rd_data;
            wake    <= next_wake;
        end
    end

    // Drive type per first-port line; second port is push-pull only
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_first
            wire [1:0] drv = DRIVE_A[2*i +: 2];
            wire       act = ~first_port_direction[i];
            assign a_drive[i] =
                act && ((drv == 2'(tlio_pkg::TLIO_PUSH_PULL)) ||
                        (drv == 2'(tlio_pkg::TLIO_OPEN_DRAIN_LOW) && !first_port[i]) ||
                        (drv == 2'(tlio_pkg::TLIO_OPEN_DRAIN_HIGH) && first_port[i]));

            // A push-pull output line is always driven; an open-drain line may only drive its own active level
            a_push_drives: assert property (@(posedge mclk) disable iff (!nrst)
                act && drv == 2'(tlio_pkg::TLIO_PUSH_PULL) |-> first_port_oe[i])
                else $error("push-pull output not driven");
            a_drain_low: assert property (@(posedge mclk) disable iff (!nrst)
                first_port_oe[i] && drv == 2'(tlio_pkg::TLIO_OPEN_DRAIN_LOW)
                |-> !first_port_out[i])
                else $error("open-drain low line drives high");
            a_drain_high: assert property (@(posedge mclk) disable iff (!nrst)
                first_port_oe[i] && drv == 2'(tlio_pkg::TLIO_OPEN_DRAIN_HIGH)
                |-> first_port_out[i])
                else $error("open-drain high line drives low");
        end
    endgenerate

    assign pad_a = '{out: first_port, oe: a_drive};
    assign pad_b = '{out: second_port, oe: ~second_port_direction & second_lines};
    assign first_port_out  = pad_a.out;
    assign first_port_oe   = pad_a.oe;
    assign second_port_out = pad_b.out;
    assign second_port_oe  = pad_b.oe;

    assign first_port_pull_up    = PULL_UP_A;
    assign first_port_pull_down  = PULL_DOWN_A;
    assign second_port_pull_up   = PULL_UP_B & second_lines;
    assign second_port_pull_down = 8'h00 & PULL_DOWN_B;

    a_latch_holds: assert property (@(posedge mclk) disable iff (!nrst)
        !(wr_en && sel_a) |=> first_port == $past(first_port))
        else $error("first port latch changed without write");
    a_write_stores: assert property (@(posedge mclk) disable iff (!nrst)
        wr_en && sel_b |=> second_port == $past(wr_data))
        else $error("second port write lost");
    a_dir_write: assert property (@(posedge mclk) disable iff (!nrst)
        wr_en && sel_ad |=> first_port_direction == $past(wr_data))
        else $error("direction write lost");
    a_input_undriven: assert property (@(posedge mclk) disable iff (!nrst)
        ((first_port_oe & first_port_direction) == 8'h00))
        else $error("input line driven");
    a_read_view: assert property (@(posedge mclk) disable iff (!nrst)
        rd_en && sel_a |=> rd_data == $past(view_a))
        else $error("first port read wrong");
    a_read_output: assert property (@(posedge mclk) disable iff (!nrst)
        rd_en && sel_b && second_port_direction == 8'h00 |=> rd_data == $past(second_port))
        else $error("output read not latch");
    a_pad_direct: assert property (@(posedge mclk) disable iff (!nrst)
        rd_en && sel_a && first_port_direction == 8'hFF |=> rd_data == $past(first_sync))
        else $error("input read not pad");
    a_missing_pads: assert property (@(posedge mclk) disable iff (!nrst)
        (second_port_oe & ~second_lines) == 8'h00)
        else $error("missing pad driven");
    a_reset_undriven: assert property (@(posedge mclk)
        !nrst |-> first_port_oe == 8'h00 && second_port_oe == 8'h00)
        else $error("line driven in reset");
    a_wake_only_halt: assert property (@(posedge mclk) disable iff (!nrst)
        wake |-> $past(halted))
        else $error("wake while running");

    // Write and read paths, refused addresses, wake and pull options
    a_first_write: assert property (@(posedge mclk) disable iff (!nrst)
        wr_en && sel_a |=> first_port == $past(wr_data))
        else $error("first port write lost");
    a_dir_b_write: assert property (@(posedge mclk) disable iff (!nrst)
        wr_en && sel_bd |=> second_port_direction == $past(wr_data))
        else $error("second direction write lost");
    a_read_holds: assert property (@(posedge mclk) disable iff (!nrst)
        !rd_en |=> rd_data == $past(rd_data))
        else $error("read data changed without read");
    a_bad_addr_read: assert property (@(posedge mclk) disable iff (!nrst)
        rd_en && !(sel_a || sel_ad || sel_b || sel_bd) |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_wake_needs_fall: assert property (@(posedge mclk) disable iff (!nrst)
        wake |-> ($past(falls & first_port_direction) != 8'h00))
        else $error("wake without input fall");
    a_no_pull_down_b: assert property (@(posedge mclk) disable iff (!nrst)
        second_port_pull_down == 8'h00)
        else $error("second port pull-down present");
    a_pull_missing: assert property (@(posedge mclk) disable iff (!nrst)
        (second_port_pull_up & ~second_lines) == 8'h00)
        else $error("pull on missing pad");

    c_write_a: cover property (@(posedge mclk) disable iff (!nrst) wr_en && sel_a);
    c_read_in: cover property (@(posedge mclk) disable iff (!nrst) rd_en && sel_b);
    c_wake:    cover property (@(posedge mclk) disable iff (!nrst) wake);
    c_read_pad: cover property (@(posedge mclk) disable iff (!nrst)
        rd_en && sel_a && first_port_direction == 8'hFF);
    c_drain_off: cover property (@(posedge mclk) disable iff (!nrst)
        !first_port_direction[1] && !first_port_oe[1]);
endmodule

//--- verif/tlio_pad_model.sv
// Board-side model of one eight-line port: drivers, pulls and floating lines
`timescale 1ns/1ps
module tlio_pad_model (
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe,
    input  wire logic [7:0] pull_up,
    input  wire logic [7:0] pull_down,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_drv,
    output logic      [7:0] pad
);
    // Device drive wins, then the board; a floating line shows the inverse
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (oe[i])
                pad[i] = out[i];
            else if (ext_drv[i])
                pad[i] = ext_val[i];
            else if (pull_up[i] | pull_down[i])
                pad[i] = pull_up[i];
            else
                pad[i] = ~ext_val[i];
        end
    end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the twelve-line port
`timescale 1ns/1ps
`include "tlio_defines.svh"
module testbench;
    logic       mclk = 1'b0;
    logic       nrst = 1'b1;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic       halted = 1'b0;
    logic       wake;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] a_val = 8'h00;
    logic [7:0] b_val = 8'h00;
    logic [7:0] drv = 8'hFF;
    logic [7:0] rd_data, got, a_pad, a_out, a_oe, a_pu, a_pd, b_pad, b_out, b_oe, b_pu, b_pd;
    int         miscompares = 0;
    int         num_checks = 0;
    always #12.5 mclk = ~mclk;
    tlio_port #(.DRIVE_A(16'h0024), .PULL_UP_A(8'h0F), .PULL_DOWN_A(8'h30), .PULL_UP_B(8'hFF),
        .PULL_DOWN_B(8'hFF)) dut_u (.mclk(mclk), .nrst(nrst), .addr(addr), .wr_en(wr_en),
        .wr_data(wr_data),
        .rd_en(rd_en), .rd_data(rd_data), .first_port_in(a_pad), .first_port_out(a_out),
        .first_port_oe(a_oe), .second_port_in(b_pad), .second_port_out(b_out),
        .second_port_oe(b_oe), .first_port_pull_up(a_pu), .first_port_pull_down(a_pd),
        .second_port_pull_up(b_pu), .second_port_pull_down(b_pd), .halted(halted), .wake(wake));
    tlio_pad_model pad_a_u (.out(a_out), .oe(a_oe), .pull_up(a_pu), .pull_down(a_pd),
        .ext_val(a_val), .ext_drv(drv), .pad(a_pad));
    tlio_pad_model pad_b_u (.out(b_out), .oe(b_oe), .pull_up(b_pu), .pull_down(b_pd),
        .ext_val(b_val), .ext_drv(drv), .pad(b_pad));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge mclk);
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge mclk);
        addr = a;
        rd_en = 1'b1;
        @(negedge mclk);
        rd_en = 1'b0;
        got = rd_data;
    endtask
    task automatic t_reset;
        chk(a_oe, 8'h00);
        chk(b_oe, 8'h00);
        rd(`TLIO_FIRST_PORT_DIR_ADDR);
        chk(got, `TLIO_DIR_RESET);
    endtask
    task automatic t_output;
        a_val = 8'hAA;
        wr(`TLIO_FIRST_PORT_ADDR, 8'h55);
        wr(`TLIO_FIRST_PORT_DIR_ADDR, 8'h00);
        chk(a_oe, 8'hFF);
        repeat (5) @(negedge mclk);
        chk(a_out, 8'h55);
        rd(`TLIO_FIRST_PORT_ADDR);
        chk(got, 8'h55);
    endtask
    task automatic t_mixed;
        a_val = 8'h3C;
        wr(`TLIO_FIRST_PORT_DIR_ADDR, 8'h0F);
        chk(a_oe, 8'hF0);
        repeat (3) @(negedge mclk);
        rd(`TLIO_FIRST_PORT_ADDR);
        chk(got, 8'h5C);
        wr(`TLIO_FIRST_PORT_ADDR, got | 8'h80);
        chk(a_out, 8'hDC);
        a_val = 8'hC3;
        repeat (3) @(negedge mclk);
        rd(`TLIO_FIRST_PORT_ADDR);
        chk(got, 8'hD3);
    endtask
    task automatic t_second;
        b_val = 8'h00;
        wr(`TLIO_SECOND_PORT_ADDR, 8'hA5);
        wr(`TLIO_SECOND_PORT_DIR_ADDR, 8'h00);
        rd(`TLIO_SECOND_PORT_ADDR);
        chk(got, 8'hA5);
        chk(b_out & `TLIO_SECOND_PORT_LINES, 8'h84);
        chk(b_oe & `TLIO_SECOND_PORT_LINES, 8'hCC);
        wr(`TLIO_SECOND_PORT_DIR_ADDR, 8'hFF);
        repeat (3) @(negedge mclk);
        rd(`TLIO_SECOND_PORT_ADDR);
        chk(got, 8'h21);
        wr(8'h20, 8'h77);
        rd(8'h20);
        chk(got, 8'h00);
    endtask
    task automatic t_wake;
        logic seen;
        halted = 1'b1;
        wr(`TLIO_FIRST_PORT_DIR_ADDR, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            a_val = 8'hFF;
            repeat (4) @(negedge mclk);
            a_val[i] = 1'b0;
            seen = 1'b0;
            repeat (6) begin
                @(negedge mclk);
                seen = seen | wake;
            end
            chk({7'h00, seen}, 8'h01);
        end
        halted = 1'b0;
        a_val = 8'hFF;
        repeat (4) @(negedge mclk);
        a_val = 8'h00;
        seen = 1'b0;
        repeat (6) begin
            @(negedge mclk);
            seen = seen | wake;
        end
        chk({7'h00, seen}, 8'h00);
    endtask
    task automatic t_pull;
        chk(a_pu, 8'h0F);
        chk(a_pd, 8'h30);
        chk(b_pu, 8'hCC);
        chk(b_pd, 8'h00);
        drv = 8'h00;
        wr(`TLIO_SECOND_PORT_DIR_ADDR, 8'hCC);
        chk(b_oe, 8'h00);
        repeat (3) @(negedge mclk);
        rd(`TLIO_FIRST_PORT_ADDR);
        chk(got & 8'h3F, 8'h0F);
        rd(`TLIO_SECOND_PORT_ADDR);
        chk(got, 8'hED);
        drv = 8'hFF;
    endtask
    task automatic t_drive;
        wr(`TLIO_FIRST_PORT_DIR_ADDR, 8'h00);
        wr(`TLIO_FIRST_PORT_ADDR, 8'h02);
        chk(a_oe, 8'hF9);
        wr(`TLIO_FIRST_PORT_ADDR, 8'hFD);
        chk(a_oe, 8'hFF);
    endtask
    task automatic t_rerun;
        rd(`TLIO_FIRST_PORT_ADDR);
        chk(got, 8'hFD);
        wr(`TLIO_SECOND_PORT_DIR_ADDR, 8'h00);
        chk(b_oe, 8'hCC);
        @(negedge mclk);
        nrst = 1'b0;
        #1;
        chk(a_oe, 8'h00);
        chk(b_oe, 8'h00);
        chk(rd_data, 8'h00);
        chk(a_out, `TLIO_DATA_RESET);
        repeat (16) @(negedge mclk);
        nrst = 1'b1;
        rd(`TLIO_FIRST_PORT_DIR_ADDR);
        chk(got, `TLIO_DIR_RESET);
        rd(`TLIO_SECOND_PORT_DIR_ADDR);
        chk(got, `TLIO_DIR_RESET);
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #1;
        nrst = 1'b0;
        repeat (16) @(negedge mclk);
        nrst = 1'b1;
        t_reset();
        t_output();
        t_mixed();
        t_second();
        t_wake();
        t_pull();
        t_drive();
        t_rerun();
        stop_test();
    end
    initial begin
        #20000;
        miscompares++;
        stop_test();
    end
endmodule
